// [shared/pcm_pkg.sv]
// Purpose: Constants for the configuration and media status register block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes: Every offset, field position, reset value and code lives here.
package pcm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] PCM_OFF_CFG = 12'h004;
  localparam logic [11:0] PCM_OFF_EE_LOAD = 12'h040;
  localparam logic [11:0] PCM_OFF_ADV = 12'h044;
  localparam logic [11:0] PCM_OFF_IRQ_STATUS = 12'h048;
  localparam logic [11:0] PCM_OFF_IRQ_MASK = 12'h04c;
  localparam logic [11:0] PCM_OFF_PHY_IRQ = 12'h050;

  // ****************************************************************
  // Field positions of the configuration register
  // ****************************************************************
  localparam int PCM_BIT_LINK = 31;
  localparam int PCM_BIT_SPEED = 30;
  localparam int PCM_BIT_DUPLEX = 29;
  localparam int PCM_BIT_REVPOL = 28;
  localparam int PCM_BIT_ANDONE = 27;
  localparam int PCM_POWERON_HI = 23;
  localparam int PCM_POWERON_LO = 18;
  localparam int PCM_BIT_AUTOCLR = 17;
  localparam int PCM_BIT_PAUSE = 16;
  localparam int PCM_SEL_HI = 15;
  localparam int PCM_SEL_LO = 13;
  localparam int PCM_BIT_EXT = 12;
  localparam int PCM_BIT_PWRDN = 9;

  // Writable bits; 26..24, 11 and 10..0 apart from 9 are not held.
  localparam logic [31:0] PCM_CFG_WMASK = 32'h00ff_f200;
  localparam logic [31:0] PCM_CFG_RESET = 32'h0000_0000;

  // ****************************************************************
  // Interrupt status bits
  // ****************************************************************
  localparam int PCM_IRQ_W = 4;
  localparam int PCM_IRQ_LINK = 0;
  localparam int PCM_IRQ_SPEED = 1;
  localparam int PCM_IRQ_DUPLEX = 2;
  localparam int PCM_IRQ_ANDONE = 3;

  // ****************************************************************
  // Advertisement vector bits and select codes
  // ****************************************************************
  localparam int PCM_ADV_10H = 0;
  localparam int PCM_ADV_10F = 1;
  localparam int PCM_ADV_100H = 2;
  localparam int PCM_ADV_100F = 3;
  localparam int PCM_ADV_PAUSE = 4;
  localparam int PCM_ADV_W = 5;

  typedef enum logic [2:0]
  {
    PCM_SEL_F10H = 3'h0,
    PCM_SEL_A10HF = 3'h1,
    PCM_SEL_F100H = 3'h2,
    PCM_SEL_A10100H = 3'h3,
    PCM_SEL_F10F = 3'h4,
    PCM_SEL_A100HF = 3'h5,
    PCM_SEL_F100F = 3'h6,
    PCM_SEL_AALL = 3'h7
  } pcm_sel_e;

  localparam logic [1:0] PCM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PCM_HSIZE_WORD = 3'h2;

endpackage

// [logic/pcm_sync.sv]
// Purpose: Two-flip-flop synchroniser for a vector of independent levels.
// Assumes: Each bit is a slow level; bits are not sampled as one word.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module pcm_sync
#(
  parameter int WIDTH = 5
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// [logic/pcm_regs.sv]
// Purpose: Configuration and media status register with AHB-Lite slave.
// Assumes: One clock hclk; transceiver status pins are asynchronous.
// Notes: Zero wait state slave; answer is always OKAY.
`timescale 1ns/1ps
`default_nettype none
module pcm_regs
  import pcm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic soft_reset,
  input wire logic eeprom_load,
  input wire logic eeprom_pause,
  input wire logic [2:0] eeprom_select,
  input wire logic link_good_flag,
  input wire logic fast_speed_flag,
  input wire logic full_duplex_flag,
  input wire logic reversed_polarity_flag,
  input wire logic autoneg_complete_flag,
  input wire logic transceiver_irq_in,
  output logic transceiver_irq_clear,
  output logic [5:0] poweron_config,
  output logic autoneg_enable,
  output logic force_fast,
  output logic force_full,
  output logic [PCM_ADV_W-1:0] advertise,
  output logic mii_enable,
  output logic transceiver_power_down,
  output logic irq
);

  if (ADDR_W < 12)
  begin : g_addr_check
    $error("ADDR_W must be at least 12");
  end

  // ****************************************************************
  // Status input synchronisation
  // ****************************************************************
  logic [5:0] st_sync;
  logic link_s, fast_s, full_s, revpol_s;
  logic andone_s, phy_irq_s;

  pcm_sync #(.WIDTH(6)) u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({transceiver_irq_in, autoneg_complete_flag,
      reversed_polarity_flag, full_duplex_flag, fast_speed_flag,
      link_good_flag}),
    .sync_out(st_sync)
  );

  assign {phy_irq_s, andone_s, revpol_s, full_s, fast_s, link_s} = st_sync;

  // ****************************************************************
  // AHB-Lite address phase capture
  // ****************************************************************
  logic dp_valid;
  logic dp_write;
  logic [ADDR_W-1:0] dp_addr;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= '0;
    end
    else
    begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end

  logic wr_cfg;
  logic wr_mask;
  logic wr_stat;
  logic rd_stat;
  logic rd_phy;

  assign wr_cfg = dp_valid && dp_write
    && dp_addr[11:0] == PCM_OFF_CFG;
  assign wr_mask = dp_valid && dp_write
    && dp_addr[11:0] == PCM_OFF_IRQ_MASK;
  assign wr_stat = dp_valid && dp_write
    && dp_addr[11:0] == PCM_OFF_IRQ_STATUS;
  assign rd_stat = dp_valid && !dp_write
    && dp_addr[11:0] == PCM_OFF_IRQ_STATUS;
  assign rd_phy = dp_valid && !dp_write
    && dp_addr[11:0] == PCM_OFF_PHY_IRQ;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  logic [31:0] cfg;
  logic ee_loaded;
  logic ee_load_q;

  // Hard reset and soft reset both return the held bits to zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= PCM_CFG_RESET;
    end
    else if (soft_reset)
    begin
      cfg <= PCM_CFG_RESET;
    end
    else if (wr_cfg)
    begin
      // Unheld bits are masked away; 26..24, 11..10 and 8..0 always read zero, 31..27 read status.
      cfg <= hwdata & PCM_CFG_WMASK;
      if (hwdata[PCM_BIT_EXT])
      begin
        cfg[PCM_BIT_PWRDN] <= 1'b1;
      end
    end
    else if (ee_load_q)
    begin
      cfg[PCM_BIT_PAUSE] <= eeprom_pause;
      cfg[PCM_SEL_HI:PCM_SEL_LO] <= eeprom_select;
    end
  end

  // The EEPROM strobe is registered and acts once; a write at once wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ee_load_q <= 1'b0;
      ee_loaded <= 1'b0;
    end
    else
    begin
      ee_load_q <= eeprom_load && !ee_loaded;
      if (ee_load_q)
      begin
        ee_loaded <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [PCM_IRQ_W-1:0] irq_stat;
  logic [PCM_IRQ_W-1:0] irq_mask;
  logic [PCM_IRQ_W-1:0] prev_st;
  logic [PCM_IRQ_W-1:0] events;
  logic [PCM_IRQ_W-1:0] clr_bits;

  assign events = {andone_s, full_s, fast_s, link_s} ^ prev_st;
  assign clr_bits = wr_stat ? hwdata[PCM_IRQ_W-1:0] : '0;

  // An event in the clearing cycle stays set.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_st <= '0;
      irq_stat <= '0;
    end
    else
    begin
      prev_st <= {andone_s, full_s, fast_s, link_s};
      irq_stat <= (irq_stat & ~clr_bits) | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_mask <= '0;
    end
    else if (wr_mask)
    begin
      irq_mask <= hwdata[PCM_IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
      transceiver_irq_clear <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat & irq_mask);
      transceiver_irq_clear <= rd_stat && cfg[PCM_BIT_AUTOCLR];
    end
  end

  // ****************************************************************
  // Transceiver controls
  // ****************************************************************
  logic [2:0] sel;
  logic [PCM_ADV_W-1:0] next_adv;
  logic next_fast;
  logic next_full;

  assign sel = cfg[PCM_SEL_HI:PCM_SEL_LO];

  always_comb
  begin
    next_adv = '0;
    next_fast = 1'b0;
    next_full = 1'b0;
    unique case (pcm_sel_e'(sel))
      PCM_SEL_F10H:
      begin
        next_fast = 1'b0;
        next_full = 1'b0;
      end
      PCM_SEL_F100H:
      begin
        next_fast = 1'b1;
      end
      PCM_SEL_F10F:
      begin
        next_full = 1'b1;
      end
      PCM_SEL_F100F:
      begin
        next_fast = 1'b1;
        next_full = 1'b1;
      end
      PCM_SEL_A10HF:
      begin
        next_adv[PCM_ADV_10H] = 1'b1;
        next_adv[PCM_ADV_10F] = 1'b1;
      end
      PCM_SEL_A10100H:
      begin
        next_adv[PCM_ADV_10H] = 1'b1;
        next_adv[PCM_ADV_100H] = 1'b1;
      end
      PCM_SEL_A100HF:
      begin
        next_adv[PCM_ADV_100H] = 1'b1;
        next_adv[PCM_ADV_100F] = 1'b1;
      end
      PCM_SEL_AALL:
      begin
        next_adv[PCM_ADV_100F:PCM_ADV_10H] = 4'hf;
      end
    endcase
    // Pause is offered only together with a full duplex ability.
    next_adv[PCM_ADV_PAUSE] = cfg[PCM_BIT_PAUSE] && sel[0]
      && (next_adv[PCM_ADV_10F] || next_adv[PCM_ADV_100F]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      autoneg_enable <= 1'b0;
      force_fast <= 1'b0;
      force_full <= 1'b0;
      advertise <= '0;
      poweron_config <= '0;
      mii_enable <= 1'b0;
      transceiver_power_down <= 1'b0;
    end
    else
    begin
      autoneg_enable <= sel[0];
      force_fast <= next_fast;
      force_full <= next_full;
      advertise <= next_adv;
      poweron_config <= cfg[PCM_POWERON_HI:PCM_POWERON_LO];
      mii_enable <= cfg[PCM_BIT_EXT];
      transceiver_power_down <= cfg[PCM_BIT_PWRDN];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] cfg_view;

  always_comb
  begin
    cfg_view = cfg & PCM_CFG_WMASK;
    cfg_view[PCM_BIT_LINK] = link_s;
    cfg_view[PCM_BIT_SPEED] = fast_s;
    cfg_view[PCM_BIT_DUPLEX] = full_s;
    cfg_view[PCM_BIT_REVPOL] = revpol_s && !fast_s;
    cfg_view[PCM_BIT_ANDONE] = andone_s || !sel[0];
  end

  // Read data is registered in the address phase, so no wait state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite)
      begin
        unique case (haddr[11:0])
          PCM_OFF_CFG: hrdata <= cfg_view;
          PCM_OFF_IRQ_STATUS: hrdata <= {28'h0, irq_stat};
          PCM_OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask};
          PCM_OFF_PHY_IRQ: hrdata <= {31'h0, phy_irq_s};
          PCM_OFF_ADV: hrdata <= {27'h0, advertise};
          PCM_OFF_EE_LOAD: hrdata <= {31'h0, ee_loaded};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [bench/pcm_regs_asserts.sv]
// Purpose: Concurrent checks on the ports of the configuration register.
// Assumes: Zero wait state slave; derived outputs lag a write by one edge.
// Notes: Soft reset suspends the checks, as it clears the register.
`timescale 1ns/1ps
`default_nettype none
module pcm_regs_asserts
  import pcm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic soft_reset,
  input wire logic transceiver_irq_clear,
  input wire logic [5:0] poweron_config,
  input wire logic autoneg_enable,
  input wire logic force_fast,
  input wire logic force_full,
  input wire logic [PCM_ADV_W-1:0] advertise,
  input wire logic mii_enable,
  input wire logic transceiver_power_down
);
  logic take;
  logic wr_q;
  logic rd_q;
  logic rdirq_q;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdirq_q <= 1'b0;
    end
    else
    begin
      wr_q <= take && hwrite && haddr[11:0] == PCM_OFF_CFG;
      rd_q <= take && !hwrite && haddr[11:0] == PCM_OFF_CFG;
      rdirq_q <= take && !hwrite && haddr[11:0] == PCM_OFF_IRQ_STATUS;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || soft_reset);
  // The data phase of a config write, then the edge that updates the register.
  sequence s_cfg_wr(c);
    wr_q && c ##1 1'b1;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_mii_select: assert property (s_cfg_wr(hwdata[12]) |=>
    mii_enable && transceiver_power_down)
    else $error("external select did not power down transceiver");
  a_poweron_copy: assert property (s_cfg_wr(1'b1) |=>
    poweron_config == $past(hwdata[23:18], 2))
    else $error("power-on configuration not copied");
  a_force_decode: assert property (s_cfg_wr(!hwdata[13]) |=>
    !autoneg_enable && force_fast == $past(hwdata[14], 2) &&
    force_full == $past(hwdata[15], 2))
    else $error("forced code decoded wrongly");
  a_auto_decode: assert property (s_cfg_wr(hwdata[13]) |=>
    autoneg_enable)
    else $error("odd code did not enable negotiation");
  a_pause_full: assert property (advertise[PCM_ADV_PAUSE] |->
    advertise[PCM_ADV_10F] || advertise[PCM_ADV_100F])
    else $error("pause advertised without full duplex");
  a_spare_zero: assert property (rd_q |->
    hrdata[26:24] == 3'h0 && hrdata[11:10] == 2'h0)
    else $error("spare bits read nonzero");
  a_revpol_slow: assert property (rd_q && hrdata[PCM_BIT_SPEED] |->
    !hrdata[PCM_BIT_REVPOL])
    else $error("polarity reported at fast speed");
  a_rdata_hold: assert property (!(take && !hwrite) |=>
    $stable(hrdata))
    else $error("read data changed without a read");
  a_clr_cause: assert property (transceiver_irq_clear |->
    rdirq_q || $past(rdirq_q) || $past(rdirq_q, 2))
    else $error("transceiver clear without status read");
endmodule
bind pcm_regs pcm_regs_asserts #(.ADDR_W(ADDR_W)) u_chk
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .soft_reset(soft_reset),
  .transceiver_irq_clear(transceiver_irq_clear),
  .poweron_config(poweron_config),
  .autoneg_enable(autoneg_enable),
  .force_fast(force_fast),
  .force_full(force_full),
  .advertise(advertise),
  .mii_enable(mii_enable),
  .transceiver_power_down(transceiver_power_down)
);
`default_nettype wire

// [bench/pcm_phy_model.sv]
// Purpose: Behavioural transceiver beside the configuration register.
// Assumes: Status levels come from the bench as one vector.
// Notes: Its interrupt stays pending until the clear pulse arrives.
`timescale 1ns/1ps
`default_nettype none
module pcm_phy_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [4:0] st,
  input wire logic irq_set,
  input wire logic transceiver_irq_clear,
  input wire logic transceiver_power_down,
  output logic [4:0] flags,
  output logic transceiver_irq_in
);
  // A transceiver in low power never reports a good link.
  assign flags = {st[4] & ~transceiver_power_down, st[3:0]};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      transceiver_irq_in <= 1'b0;
    else if (irq_set)
      transceiver_irq_in <= 1'b1;
    else if (transceiver_irq_clear)
      transceiver_irq_in <= 1'b0;
  end
endmodule
`default_nettype wire

// [bench/tb_phy_config_media_status_reg.sv]
// Purpose: Self-checking bench for the configuration register.
// Assumes: Single-slave AHB-Lite bus, hready tied to hreadyout.
// Notes: Random data come from a fixed seed, so runs repeat.
`timescale 1ns/1ps
`default_nettype none
module tb_phy_config_media_status_reg;
  import pcm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r, d, held;
  logic hreadyout, hresp, irq, clr, irq_in, mii, pd, ane, ffast, ffull;
  logic soft_reset = 1'b0;
  logic eeprom_load = 1'b0;
  logic eeprom_pause = 1'b1;
  logic [2:0] eeprom_select = 3'h0;
  logic [4:0] st = 5'h0;
  logic [4:0] flags, adv;
  logic irq_set = 1'b0;
  logic [5:0] pcfg;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'hb22aea05;
  always #2 hclk = ~hclk;
  pcm_regs u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .soft_reset(soft_reset), .eeprom_load(eeprom_load),
    .eeprom_pause(eeprom_pause), .eeprom_select(eeprom_select),
    .link_good_flag(flags[4]), .fast_speed_flag(flags[3]),
    .full_duplex_flag(flags[2]), .reversed_polarity_flag(flags[1]),
    .autoneg_complete_flag(flags[0]), .transceiver_irq_in(irq_in),
    .transceiver_irq_clear(clr), .poweron_config(pcfg),
    .autoneg_enable(ane), .force_fast(ffast), .force_full(ffull),
    .advertise(adv), .mii_enable(mii), .transceiver_power_down(pd),
    .irq(irq)
  );
  pcm_phy_model u_phy
  (
    .hclk(hclk), .hresetn(hresetn), .st(st), .irq_set(irq_set),
    .transceiver_irq_clear(clr), .transceiver_power_down(pd),
    .flags(flags), .transceiver_irq_in(irq_in)
  );
  task automatic complete_run;
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64)
    begin
      @(posedge hclk);
      n++;
    end
    if (n == 64)
    begin
      failures++;
      complete_run();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w,
    input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PCM_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= PCM_HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    wait_rdy();
    r = hrdata;
  endtask
  // Status bits come from the pins, so the pin vector is part of the key.
  function automatic logic [31:0] exp_cfg(input logic [31:0] h,
    input logic [4:0] s);
    logic [31:0] v;
    v = h & PCM_CFG_WMASK;
    v[31] = s[4] & ~h[9];
    v[30] = s[3];
    v[29] = s[2];
    v[28] = s[1] & ~s[3];
    v[27] = s[0] | ~h[13];
    return v;
  endfunction
  function automatic logic [4:0] exp_adv(input logic [31:0] h);
    logic [4:0] a;
    case (h[15:13])
      3'h1: a = 5'h03;
      3'h3: a = 5'h05;
      3'h5: a = 5'h0c;
      default: a = 5'h0f;
    endcase
    a[4] = h[16] & (a[1] | a[3]);
    return a;
  endfunction
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    bus(PCM_OFF_CFG, 1'b0, 32'h0);
    chk(r, exp_cfg(32'h0, 5'h0));
    eeprom_select <= 3'h1 | 3'($random(seed));
    eeprom_load <= 1'b1;
    @(posedge hclk);
    eeprom_load <= 1'b0;
    repeat (4) @(posedge hclk);
    held = {15'h0, eeprom_pause, eeprom_select, 13'h0};
    bus(PCM_OFF_CFG, 1'b0, 32'h0);
    chk(r, exp_cfg(held, st));
    chk(adv, exp_adv(held));
    bus(12'h100, 1'b1, 32'hffff_ffff);
    bus(12'h100, 1'b0, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      d = $random(seed);
      d[15:13] = i[2:0];
      st <= 5'($random(seed));
      bus(PCM_OFF_CFG, 1'b1, d);
      held = d & PCM_CFG_WMASK;
      if (d[12])
        held[9] = 1'b1;
      repeat (6) @(posedge hclk);
      bus(PCM_OFF_CFG, 1'b0, 32'h0);
      chk(r, exp_cfg(held, st));
      chk({pcfg, mii, pd}, {held[23:18], held[12], held[9]});
      if (held[13])
        chk({ane, adv}, {1'b1, exp_adv(held)});
      else
        chk({ane, ffast, ffull}, {1'b0, held[14], held[15]});
    end
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    repeat (6) @(posedge hclk);
    bus(PCM_OFF_CFG, 1'b0, 32'h0);
    chk(r, exp_cfg(32'h0, st));
    bus(PCM_OFF_IRQ_STATUS, 1'b1, 32'hf);
    bus(PCM_OFF_IRQ_MASK, 1'b1, 32'h1);
    st <= st ^ 5'h10;
    repeat (6) @(posedge hclk);
    chk(irq, 1'b1);
    bus(PCM_OFF_IRQ_STATUS, 1'b0, 32'h0);
    chk(r, 32'h0000_0001);
    bus(PCM_OFF_IRQ_STATUS, 1'b1, 32'h1);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    bus(PCM_OFF_IRQ_MASK, 1'b1, 32'h0);
    st <= st ^ 5'h10;
    repeat (6) @(posedge hclk);
    chk(irq, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      bus(PCM_OFF_CFG, 1'b1, {14'h0, k[0], 17'h0});
      irq_set <= 1'b1;
      @(posedge hclk);
      irq_set <= 1'b0;
      repeat (4) @(posedge hclk);
      bus(PCM_OFF_IRQ_STATUS, 1'b0, 32'h0);
      repeat (4) @(posedge hclk);
      bus(PCM_OFF_PHY_IRQ, 1'b0, 32'h0);
      chk(r, {31'h0, ~k[0]});
    end
    complete_run();
  end
endmodule
`default_nettype wire
